// ---- hdl/out_path_pkg.sv ----
// Purpose: constants for the output path enable controller
// Assumes: 16-bit register port, 25 MHz system clock
// Notes: register indices are word addresses on the register port
// Behaviour
// - enable bits per path at fixed positions
// - status bits mirror enables, split over two registers
// - every path muted out of reset
// - charge pump runs automatically for paths 0-5
// - enable change on paths 0-7 starts pop-suppressed sequence
// - sequence completion offered as interrupt source
// - sequence status routed to general-purpose output
// - enable refused when clock cycles insufficient
// - refused enable leaves active paths untouched
// - refusal raises underclock error for irq/gpio
// - status shows which paths really came up
// - per-path mute bit, one mutes, resets one
package out_path_pkg;
  localparam int          NUM_PATHS       = 10;
  localparam logic [11:0] ENABLES_ADDR    = 12'h400;
  localparam logic [11:0] STATUS_HI_ADDR  = 12'h401;
  localparam logic [11:0] STATUS_LO_ADDR  = 12'h406;
  // per-path digital mute registers, indexed by path bit
  localparam logic [11:0] MUTE_ADDR [NUM_PATHS] = '{
    12'h415, 12'h411, 12'h41d, 12'h419, 12'h000,
    12'h421, 12'h429, 12'h425, 12'h431, 12'h42d};
  localparam int          MUTE_BIT        = 8;
  localparam logic [9:0]  VALID_MASK      = 10'h3ef;
  localparam logic [9:0]  STATUS_HI_MASK  = 10'h3c0;
  localparam logic [9:0]  STATUS_LO_MASK  = 10'h02f;
  localparam logic [9:0]  CPUMP_MASK      = 10'h02f;
  localparam logic [9:0]  POP_SEQ_MASK    = 10'h0ef;
  localparam logic [9:0]  ENABLE_RESET    = 10'h000;
  localparam logic [9:0]  MUTE_RESET      = 10'h3ff;
  localparam int          SYS_CLK_KHZ     = 25000;
  localparam int          SEQ_TIME_US     = 280;
  localparam int          SEQ_CYCLES      = SEQ_TIME_US * SYS_CLK_KHZ / 1000;
  localparam logic [7:0]  COST_ANALOGUE   = 8'h02;
  localparam logic [7:0]  COST_PDM        = 8'h01;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CHECK, SEQ_RUN} seq_state_t;
endpackage : out_path_pkg

// ---- hdl/output_path_enable_control.sv ----
// Purpose: output path enable sequencing, status and mute control
// Assumes: register port synchronous to sys_clk_i, one access a cycle
// Notes: one path sequence at a time, lowest bit served first
`timescale 1ns/1ps
`default_nettype none
module output_path_enable_control #(
  parameter int SEQ_CYCLES = out_path_pkg::SEQ_CYCLES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic [7:0]  system_core_clock_budget_i,
  output logic      [9:0]  path_on_o,
  output logic      [9:0]  path_mute_o,
  output logic             charge_pump_on_o,
  output logic             seq_busy_o,
  output logic             seq_done_o,
  output logic             underclock_o
);
  localparam int N = out_path_pkg::NUM_PATHS;

  function automatic logic [7:0] path_cost(input int idx);
    path_cost = (idx >= 8) ? out_path_pkg::COST_PDM
                           : out_path_pkg::COST_ANALOGUE;
  endfunction : path_cost

  function automatic logic [3:0] first_set(input logic [9:0] v);
    first_set = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction : first_set

  logic [9:0]               enable_ff, nxt_enable;
  logic [9:0]               state_ff, nxt_state;
  logic [9:0]               reject_ff, nxt_reject;
  logic [9:0]               mute_ff, nxt_mute;
  logic [15:0]              rdata_ff, nxt_rdata;
  out_path_pkg::seq_state_t seq_ff, nxt_seq;
  logic [3:0]               idx_ff, nxt_idx;
  logic [31:0]              cnt_ff, nxt_cnt;
  logic                     done_ff, nxt_done;
  logic                     uc_ff, nxt_uc;
  logic                     busy_ff, nxt_busy;
  logic                     cp_ff, nxt_cp;

  logic [9:0]  pending;
  logic [8:0]  load;
  logic [8:0]  need;
  logic [9:0]  wmask;

  always_comb begin
    nxt_enable = enable_ff;
    nxt_state  = state_ff;
    nxt_reject = reject_ff;
    nxt_mute   = mute_ff;
    nxt_rdata  = rdata_ff;
    nxt_seq    = seq_ff;
    nxt_idx    = idx_ff;
    nxt_cnt    = cnt_ff;
    nxt_done   = 1'b0;
    nxt_uc     = 1'b0;
    wmask      = 10'h000;
    load       = 9'h000;
    for (int i = 0; i < N; i++) begin
      if (state_ff[i]) begin
        load = load + {1'b0, path_cost(i)};
      end
    end
    need = load + {1'b0, path_cost(int'(idx_ff))};

    // register writes; reserved bits never stored
    if (reg_wr_i && reg_addr_i == out_path_pkg::ENABLES_ADDR) begin
      nxt_enable = reg_wdata_i[9:0] & out_path_pkg::VALID_MASK;
      // only a write that changes a refused path's enable bit lets it be tried again
      wmask = nxt_enable ^ enable_ff;
    end
    for (int i = 0; i < N; i++) begin
      if (out_path_pkg::VALID_MASK[i] && reg_wr_i &&
          reg_addr_i == out_path_pkg::MUTE_ADDR[i]) begin
        nxt_mute[i] = reg_wdata_i[out_path_pkg::MUTE_BIT];
      end
    end
    if (reg_rd_i) begin
      nxt_rdata = 16'h0000;
      if (reg_addr_i == out_path_pkg::ENABLES_ADDR) begin
        nxt_rdata = {6'h00, enable_ff};
      end else if (reg_addr_i == out_path_pkg::STATUS_HI_ADDR) begin
        nxt_rdata = {6'h00, state_ff & out_path_pkg::STATUS_HI_MASK};
      end else if (reg_addr_i == out_path_pkg::STATUS_LO_ADDR) begin
        nxt_rdata = {6'h00, state_ff & out_path_pkg::STATUS_LO_MASK};
      end
      for (int i = 0; i < N; i++) begin
        if (out_path_pkg::VALID_MASK[i] &&
            reg_addr_i == out_path_pkg::MUTE_ADDR[i]) begin
          nxt_rdata = 16'h0000;
          nxt_rdata[out_path_pkg::MUTE_BIT] = mute_ff[i];
        end
      end
    end

    pending = (enable_ff ^ state_ff) & ~reject_ff;
    unique case (seq_ff)
      out_path_pkg::SEQ_IDLE: begin
        if (|pending) begin
          nxt_idx = first_set(pending);
          nxt_seq = out_path_pkg::SEQ_CHECK;
        end
      end
      out_path_pkg::SEQ_CHECK: begin
        if (enable_ff[idx_ff] == state_ff[idx_ff]) begin
          nxt_seq = out_path_pkg::SEQ_IDLE;
        end else if (enable_ff[idx_ff] &&
                     need > {1'b0, system_core_clock_budget_i}) begin
          // refused: active paths keep running, status unchanged
          nxt_reject[idx_ff] = 1'b1;
          nxt_uc             = 1'b1;
          nxt_seq            = out_path_pkg::SEQ_IDLE;
        end else if (out_path_pkg::POP_SEQ_MASK[idx_ff]) begin
          nxt_cnt = 32'(SEQ_CYCLES - 1);
          nxt_seq = out_path_pkg::SEQ_RUN;
        end else begin
          nxt_state[idx_ff] = enable_ff[idx_ff];
          nxt_done          = 1'b1;
          nxt_seq           = out_path_pkg::SEQ_IDLE;
        end
      end
      out_path_pkg::SEQ_RUN: begin
        if (cnt_ff == 32'h0000_0000) begin
          // target taken at completion, so a late flip is honoured
          nxt_state[idx_ff] = enable_ff[idx_ff];
          nxt_done          = 1'b1;
          nxt_seq           = out_path_pkg::SEQ_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 32'h0000_0001;
        end
      end
    endcase
    nxt_reject = (nxt_reject & ~wmask) & nxt_enable;
    nxt_busy   = (nxt_seq != out_path_pkg::SEQ_IDLE);
    // pump stays up while a pump-fed path is on or changing
    nxt_cp = |((nxt_state | ((nxt_seq == out_path_pkg::SEQ_RUN) ?
             (10'h001 << nxt_idx) : 10'h000)) &
             out_path_pkg::CPUMP_MASK);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_ff <= out_path_pkg::ENABLE_RESET;
      state_ff  <= out_path_pkg::ENABLE_RESET;
      reject_ff <= 10'h000;
      mute_ff   <= out_path_pkg::MUTE_RESET;
      rdata_ff  <= 16'h0000;
      seq_ff    <= out_path_pkg::SEQ_IDLE;
      idx_ff    <= 4'h0;
      cnt_ff    <= 32'h0000_0000;
      done_ff   <= 1'b0;
      uc_ff     <= 1'b0;
      busy_ff   <= 1'b0;
      cp_ff     <= 1'b0;
    end else begin
      enable_ff <= nxt_enable;
      state_ff  <= nxt_state;
      reject_ff <= nxt_reject;
      mute_ff   <= nxt_mute;
      rdata_ff  <= nxt_rdata;
      seq_ff    <= nxt_seq;
      idx_ff    <= nxt_idx;
      cnt_ff    <= nxt_cnt;
      done_ff   <= nxt_done;
      uc_ff     <= nxt_uc;
      busy_ff   <= nxt_busy;
      cp_ff     <= nxt_cp;
    end
  end

  assign reg_rdata_o      = rdata_ff;
  assign path_on_o        = state_ff;
  assign path_mute_o      = mute_ff;
  assign charge_pump_on_o = cp_ff;
  assign seq_busy_o       = busy_ff;
  assign seq_done_o       = done_ff;
  assign underclock_o     = uc_ff;
endmodule : output_path_enable_control
`default_nettype wire

// ---- verif/output_path_monitor.sv ----
// Purpose: port checker for the output path enable controller
// Assumes: one clock domain, async active-high reset
// Notes: status may only move on a completion pulse
`timescale 1ns/1ps
`default_nettype none
module output_path_monitor #(parameter int SEQ_CYCLES = 10) (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [7:0]  system_core_clock_budget_i,
  input wire logic [9:0]  path_on_o,
  input wire logic [9:0]  path_mute_o,
  input wire logic        charge_pump_on_o,
  input wire logic        seq_busy_o,
  input wire logic        seq_done_o,
  input wire logic        underclock_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_status_on_done: assert property (
    $changed(path_on_o) |-> seq_done_o) else $error("status moved");
  a_refusal_keeps: assert property (
    underclock_o |-> $stable(path_on_o)) else $error("refusal moved status");
  a_refusal_pulse: assert property (
    underclock_o |-> !seq_done_o ##1 !underclock_o) else $error("bad refusal");
  a_done_pulse: assert property (
    seq_done_o |=> !seq_done_o) else $error("done stretched");
  a_pump_follows: assert property (
    |(path_on_o & 10'h02f) |-> charge_pump_on_o) else $error("pump off");
  a_unused_bit: assert property (
    !path_on_o[4] && path_mute_o[4]) else $error("bit 4 moved");
  a_status_read: assert property (
    reg_rd_i && reg_addr_i == 12'h401 |=>
    reg_rdata_o == {6'h00, $past(path_on_o) & 10'h3c0}) else $error("bad read");
  a_mute_write: assert property (
    reg_wr_i && reg_addr_i == 12'h415 |=>
    path_mute_o[0] == $past(reg_wdata_i[8])) else $error("mute lost");
endmodule : output_path_monitor
bind output_path_enable_control output_path_monitor #(.SEQ_CYCLES(SEQ_CYCLES))
  output_path_monitor_i (.*);
`default_nettype wire

// ---- verif/output_path_enable_control_test.sv ----
// Purpose: register-level test of the output path enable controller
// Assumes: SEQ_CYCLES cut to 10 to keep the run short
// Notes: refusal pulses are counted in the background
`timescale 1ns/1ps
`default_nettype none
module output_path_enable_control_test;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
  logic [7:0]  system_core_clock_budget_i = 8'h04;
  logic [9:0]  path_on_o, path_mute_o;
  logic        charge_pump_on_o, seq_busy_o, seq_done_o, underclock_o;
  int          miscompares = 0, samples_checked = 0, refusals = 0, cycles = 0;
  int          dones = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  output_path_enable_control #(.SEQ_CYCLES(10))
    output_path_enable_control_i (.*);
  always @(posedge sys_clk_i) begin
    cycles   <= cycles + 1;
    refusals <= refusals + int'(underclock_o === 1'b1);
    dones    <= dones + int'(seq_done_o === 1'b1);
    if (cycles == 3000) begin // far above the few hundred cycles needed
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic w, logic [11:0] a, logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= w;
    reg_rd_i    <= !w;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1 if (!w) check(reg_rdata_o, d); // on reads d is the expected word
  endtask : acc
  task automatic settle(input logic [9:0] on, input int nu);
    do @(posedge sys_clk_i);
    while (path_on_o !== on || refusals != nu || seq_busy_o !== 1'b0);
  endtask : settle
  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    acc(0, 12'h415, 16'h0100);
    acc(1, 12'h46c, 16'h0c01);
    acc(1, 12'h46e, 16'h0c01);
    acc(1, 12'h470, 16'h0c01);
    acc(1, 12'h400, 16'hffff);
    acc(0, 12'h400, 16'h03ef);
    settle(10'h003, 7);
    check(16'(charge_pump_on_o), 16'h0001);
    system_core_clock_budget_i <= 8'hff;
    acc(0, 12'h406, 16'h0003);
    acc(1, 12'h400, 16'h0003);
    acc(1, 12'h400, 16'h03ef);
    acc(0, 12'h401, 16'h0000);
    settle(10'h3ef, 7);
    acc(0, 12'h401, 16'h03c0);
    acc(0, 12'h406, 16'h002f);
    acc(1, 12'h415, 16'h0000);
    check(16'(path_mute_o), 16'h03fe);
    acc(0, 12'h7ff, 16'h0000);
    acc(1, 12'h415, 16'h0100);
    acc(1, 12'h400, 16'h0000);
    settle(10'h000, 7);
    check(16'(charge_pump_on_o), 16'h0000);
    acc(1, 12'h46c, 16'h0801);
    acc(1, 12'h46e, 16'h0801);
    acc(1, 12'h470, 16'h0801);
    check(16'(dones), 16'h0012);
    acc(1, 12'h415, 16'h0000);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    #1 check(16'(path_mute_o), 16'h03ff);
    check(16'(path_on_o), 16'h0000);
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    acc(0, 12'h415, 16'h0100);
    tally_and_finish();
  end
endmodule : output_path_enable_control_test
`default_nettype wire
